// File: src/mxsec_fsm.sv
// mxsec_fsm: limit security command engine for the shared limit opcode
// assumes: command and data bytes come decoded from the link layer,
// one command at a time; the limit-address set itself is done elsewhere
`timescale 1ns/100ps
// Notes on behaviour
// - opcode after native read means limit set
// - feature picks password, lock, unlock, freeze
// - accepted lock enters locked state
// - locked rejects all but unlock and freeze
// - locked until power cycle, unlock, freeze
// - unlock takes one sector, compares password
// - mismatch aborts and decrements attempt counter
// - attempt counter starts at five
// - zero attempts rejects unlock until reset
// - match enters unlocked, accepts all but unknown features and unlock at zero attempts
// - freeze enters frozen, rejects later commands
// - frozen disables set, password, lock, unlock
// - password kept only until power cycle
module mxsec_fsm
  import mxsec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire mxsec_pkg::mxsec_cmd_t i_cmd,
  input wire mxsec_pkg::mxsec_byte_t i_data,
  output logic o_data_req,
  output logic o_set_limit,
  output logic o_done,
  output logic [7:0] o_command_error_flags,
  output logic [7:0] o_device_status_flags,
  output mxsec_pkg::mxsec_lstate_t o_lstate
);
  import mxsec_pkg::*;

  mxsec_lstate_t lstate_q, lstate_d;
  mxsec_phase_t phase_q, phase_d;
  logic native_q;
  logic is_pw_q;
  logic [8:0] idx_q;
  logic data_req_q, set_limit_q, done_q, abort_q, dec_q;
  logic [7:0] err_q, stat_q;
  logic match;
  logic exhausted;

  wire is_limit = i_cmd.valid && i_cmd.opcode == MXSEC_OP_LIMIT;
  wire is_native = i_cmd.valid && i_cmd.opcode == MXSEC_OP_READ_NATIVE;
  wire cmd_set = is_limit && native_q;
  wire sub = is_limit && !native_q;
  wire f_pw = sub && i_cmd.feature == MXSEC_FEAT_SET_PW;
  wire f_lock = sub && i_cmd.feature == MXSEC_FEAT_LOCK;
  wire f_unlock = sub && i_cmd.feature == MXSEC_FEAT_UNLOCK;
  wire f_freeze = sub && i_cmd.feature == MXSEC_FEAT_FREEZE;
  wire f_bad = sub && !(f_pw || f_lock || f_unlock || f_freeze);
  wire in_lock = lstate_q == MXSEC_LOCKED;
  wire in_frz = lstate_q == MXSEC_FROZEN;
  // locked allows only unlock and freeze
  wire rej_lock = in_lock && (cmd_set || f_pw || f_lock);
  // frozen rejects every limit command
  wire rej_frz = in_frz && is_limit;
  wire rej_unl = f_unlock && exhausted;
  wire reject = rej_lock || rej_frz || rej_unl || f_bad;
  wire idle = phase_q == MXSEC_IDLE;
  wire take = idle && is_limit;
  wire ok = take && !reject;
  wire start_data = ok && (f_pw || f_unlock);
  wire last_byte = i_data.valid && idx_q == 9'(MXSEC_SECTOR_BYTES - 1);
  wire data_end = phase_q == MXSEC_DATA && last_byte;
  wire unl_fail = data_end && !is_pw_q && !match;

  always_comb begin
    lstate_d = lstate_q;
    if (ok && f_lock) begin
      lstate_d = MXSEC_LOCKED;
    end else if (ok && f_freeze) begin
      lstate_d = MXSEC_FROZEN;
    end else if (data_end && !is_pw_q && match) begin
      lstate_d = MXSEC_UNLOCKED;
    end else if (data_end && is_pw_q) begin
      lstate_d = MXSEC_UNLOCKED;
    end
  end

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      MXSEC_IDLE: begin
        if (start_data) begin
          phase_d = MXSEC_DATA;
        end else if (take) begin
          phase_d = MXSEC_DONE;
        end
      end
      MXSEC_DATA: begin
        if (last_byte) begin
          phase_d = MXSEC_DONE;
        end
      end
      MXSEC_DONE: begin
        phase_d = MXSEC_IDLE;
      end
      default: begin
        phase_d = MXSEC_IDLE;
      end
    endcase
  end

  // error and status images for the completion
  wire fail = (take && reject) || unl_fail;
  wire [7:0] err_d = fail ? (8'h01 << MXSEC_ERR_ABT) : 8'h00;
  wire [7:0] stat_d = (8'h01 << MXSEC_ST_RDY) | (8'h01 << MXSEC_ST_DSC) |
                      (fail ? (8'h01 << MXSEC_ST_ERR) : 8'h00);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lstate_q <= MXSEC_UNLOCKED;
      phase_q <= MXSEC_IDLE;
    end else begin
      lstate_q <= lstate_d;
      phase_q <= phase_d;
    end
  end

  // native read arms the set form for exactly the next command
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      native_q <= 1'b0;
    end else if (i_cmd.valid && idle) begin
      native_q <= is_native;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idx_q <= 9'h000;
      is_pw_q <= 1'b0;
    end else if (start_data) begin
      idx_q <= 9'h000;
      is_pw_q <= f_pw;
    end else if (phase_q == MXSEC_DATA && i_data.valid) begin
      idx_q <= idx_q + 9'h001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_req_q <= 1'b0;
      set_limit_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      data_req_q <= phase_d == MXSEC_DATA;
      set_limit_q <= ok && cmd_set;
      done_q <= phase_d == MXSEC_DONE;
      abort_q <= fail;
      dec_q <= unl_fail;
    end
  end

  // flags update only when a command finishes, so a polled read is stable
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_q <= MXSEC_ERR_RESET;
      stat_q <= MXSEC_STAT_RESET;
    end else if ((take && !start_data) || data_end) begin
      err_q <= err_d;
      stat_q <= stat_d;
    end
  end

  mxsec_pw_store u_pw (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_load(is_pw_q),
    .i_sector_start(start_data),
    .i_byte(phase_q == MXSEC_DATA ? i_data : '0),
    .i_index(idx_q),
    .o_match(match)
  );

  mxsec_tries u_tries (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_dec(dec_q),
    .o_exhausted(exhausted),
    .o_count()
  );

  assign o_data_req = data_req_q;
  assign o_set_limit = set_limit_q;
  assign o_done = done_q;
  assign o_command_error_flags = err_q;
  assign o_device_status_flags = stat_q;
  assign o_lstate = lstate_q;
endmodule : mxsec_fsm

// File: src/mxsec_pkg.sv
// mxsec_pkg: opcodes, subcommand codes, register bit positions, state encodings
// assumes: used by the limit security state machine and its two helpers
package mxsec_pkg;
  localparam logic [7:0] MXSEC_OP_LIMIT = 8'hf9;
  localparam logic [7:0] MXSEC_OP_READ_NATIVE = 8'hf8;
  localparam logic [7:0] MXSEC_FEAT_SET_PW = 8'h01;
  localparam logic [7:0] MXSEC_FEAT_LOCK = 8'h02;
  localparam logic [7:0] MXSEC_FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] MXSEC_FEAT_FREEZE = 8'h04;
  localparam logic [2:0] MXSEC_TRIES_INIT = 3'h5;
  localparam int MXSEC_PW_BYTES = 32;
  localparam int MXSEC_PW_FIRST = 2;
  localparam int MXSEC_SECTOR_BYTES = 512;
  localparam int MXSEC_ERR_ABT = 2;
  localparam int MXSEC_ST_BSY = 7;
  localparam int MXSEC_ST_RDY = 6;
  localparam int MXSEC_ST_DF = 5;
  localparam int MXSEC_ST_DSC = 4;
  localparam int MXSEC_ST_DRQ = 3;
  localparam int MXSEC_ST_COR = 2;
  localparam int MXSEC_ST_ERR = 0;
  localparam logic [7:0] MXSEC_ERR_RESET = 8'h00;
  localparam logic [7:0] MXSEC_STAT_RESET = 8'h50;

  typedef enum logic [1:0] {
    MXSEC_UNLOCKED = 2'b00,
    MXSEC_LOCKED = 2'b01,
    MXSEC_FROZEN = 2'b10
  } mxsec_lstate_t;

  typedef enum logic [1:0] {
    MXSEC_IDLE = 2'b00,
    MXSEC_DATA = 2'b01,
    MXSEC_DONE = 2'b10
  } mxsec_phase_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] feature;
  } mxsec_cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mxsec_byte_t;
endpackage : mxsec_pkg

// File: src/mxsec_pw_store.sv
// mxsec_pw_store: holds the limit password, captured from a sector stream
// assumes: bytes arrive in order; content is lost only on reset
`timescale 1ns/100ps
module mxsec_pw_store
  import mxsec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic i_sector_start,
  input wire mxsec_pkg::mxsec_byte_t i_byte,
  input wire logic [8:0] i_index,
  output logic o_match
);
  import mxsec_pkg::*;
  logic [7:0] pw_q [MXSEC_PW_BYTES];
  logic match_q;
  wire in_pw = (i_index >= 9'(MXSEC_PW_FIRST)) &&
               (i_index < 9'(MXSEC_PW_FIRST + MXSEC_PW_BYTES));
  wire [4:0] slot = 5'(i_index - 9'(MXSEC_PW_FIRST));
  wire mism = i_byte.valid && in_pw && (pw_q[slot] != i_byte.data);

  genvar g;
  generate
    for (g = 0; g < MXSEC_PW_BYTES; g++) begin : g_pw
      // power cycle alone clears the password
      always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          pw_q[g] <= 8'h00;
        end else if (i_load && i_byte.valid && in_pw && slot == 5'(g)) begin
          pw_q[g] <= i_byte.data;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      match_q <= 1'b1;
    end else if (i_sector_start) begin
      match_q <= 1'b1;
    end else if (!i_load && mism) begin
      match_q <= 1'b0;
    end
  end
  assign o_match = match_q;
endmodule : mxsec_pw_store

// File: src/mxsec_tries.sv
// mxsec_tries: unlock attempt counter, starts at five
// assumes: decrement pulses come from the command engine
`timescale 1ns/100ps
module mxsec_tries
  import mxsec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_dec,
  output logic o_exhausted,
  output logic [2:0] o_count
);
  import mxsec_pkg::*;
  logic [2:0] cnt_q;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= MXSEC_TRIES_INIT;
    end else if (i_dec && cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign o_exhausted = (cnt_q == 3'h0);
  assign o_count = cnt_q;
endmodule : mxsec_tries

// File: verification/mxsec_monitor.sv
// monitor: completion flags and limit state at the engine ports
// assumes: bound into mxsec_fsm, one clock
`timescale 1ns/100ps
module mxsec_monitor
  import mxsec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire mxsec_pkg::mxsec_byte_t i_data,
  input wire logic o_data_req,
  input wire logic o_set_limit,
  input wire logic o_done,
  input wire logic [7:0] o_command_error_flags,
  input wire logic [7:0] o_device_status_flags,
  input wire mxsec_pkg::mxsec_lstate_t o_lstate
);
  logic [9:0] n_q;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) n_q <= '0;
    else n_q <= o_data_req ? n_q + {9'h000, i_data.valid} : 10'h000;
  end
  AST_FLAGS: assert property (o_done |->
    {o_command_error_flags, o_device_status_flags} inside {16'h0451, 16'h0050})
    else $error("bad flags");
  AST_DONE_PULSE: assert property (o_done |=> !o_done)
    else $error("long done");
  AST_CHANGE_DONE: assert property ($changed(o_lstate) |->
    o_done && o_command_error_flags == 8'h00) else $error("state change not accepted");
  AST_FROZEN_HOLD: assert property (o_lstate == MXSEC_FROZEN |=>
    o_lstate == MXSEC_FROZEN) else $error("left frozen");
  AST_FROZEN_ABORT: assert property (o_done && $past(o_lstate, 2) == MXSEC_FROZEN |->
    o_command_error_flags == 8'h04) else $error("frozen accepted");
  AST_LIMIT_UNLOCKED: assert property (o_set_limit |-> o_lstate == MXSEC_UNLOCKED)
    else $error("limit set while guarded");
  AST_SECTOR: assert property ($fell(o_data_req) |-> n_q == 10'd512 && o_done)
    else $error("sector length");
  AST_LOCK_EXIT: assert property (o_lstate == MXSEC_LOCKED ##1
    o_lstate != MXSEC_LOCKED |-> o_command_error_flags == 8'h00) else $error("bad exit");
endmodule : mxsec_monitor

// File: verification/mxsec_host.sv
// host model: sends one sector per request, password bytes all i_key
// assumes: i_slow leaves an idle cycle between bytes
`timescale 1ns/100ps
module mxsec_host
  import mxsec_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_req,
  input wire logic [7:0] i_key,
  input wire logic i_slow,
  output mxsec_pkg::mxsec_byte_t o_byte
);
  int n = 0;
  int seed = 32'ha216;
  logic gap = 1'b0;
  initial o_byte = '0;
  always @(negedge i_mclk) begin
    gap <= i_slow && !gap;
    // idle line toggles so a stale byte never reads as held
    o_byte <= {1'b0, ~o_byte.data};
    if (i_req && n < MXSEC_SECTOR_BYTES && !gap) begin
      o_byte <= {1'b1, (n >= MXSEC_PW_FIRST && n < MXSEC_PW_FIRST + MXSEC_PW_BYTES) ?
        i_key : 8'($random(seed))};
      n <= n + 1;
    end
    if (!i_req) n <= 0;
  end
endmodule : mxsec_host

// File: verification/max_address_security_fsm_tb.sv
// bench: limit commands in, completions checked in order from a queue
// assumes: mxsec_host answers every sector request
`timescale 1ns/100ps
module max_address_security_fsm_tb;
  import mxsec_pkg::*;
  logic i_mclk = 0, i_reset_n = 0, slow = 0, o_data_req, o_set_limit, o_done;
  logic [7:0] key = 8'h00, err, stat;
  mxsec_cmd_t cmd = '0;
  mxsec_byte_t dat;
  mxsec_lstate_t ls;
  logic [18:0] expq[$];
  int n_mismatch = 0, comparisons = 0, seed = 32'ha216, i, k;
  mxsec_fsm mxsec_fsm_inst(.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_cmd(cmd), .i_data(dat),
    .o_data_req(o_data_req), .o_set_limit(o_set_limit), .o_done(o_done),
    .o_command_error_flags(err), .o_device_status_flags(stat), .o_lstate(ls));
  mxsec_host mxsec_host_inst(.i_mclk(i_mclk), .i_req(o_data_req), .i_key(key),
    .i_slow(slow), .o_byte(dat));
  initial forever #4 i_mclk = ~i_mclk;
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  function automatic logic [18:0] r(input logic ab, input mxsec_lstate_t s);
    return {1'b0, ab ? 16'h0451 : 16'h0050, s};
  endfunction : r
  // a set-limit expectation, or feature bit 7, sends the native read first
  task automatic op(input logic [7:0] ft, input logic [18:0] e);
    expq.push_back(e);
    for (k = (e[18] || ft[7]) ? 0 : 1; k < 2; k++) begin
      @(negedge i_mclk);
      cmd = {1'b1, k ? 8'hf9 : 8'hf8, ft};
    end
    @(negedge i_mclk);
    cmd.valid = 1'b0;
    for (k = 0; !(o_done || o_set_limit); k++) begin
      if (k > 1100) begin
        n_mismatch++;
        stop_test();
      end
      @(negedge i_mclk);
    end
    // engine is still busy in the done cycle; next command one cycle later
    @(negedge i_mclk);
  endtask : op
  task automatic rst;
    i_reset_n = 0;
    repeat (4) @(negedge i_mclk);
    i_reset_n = 1;
    check({1'b0, err, stat, ls}, r(0, MXSEC_UNLOCKED));
  endtask : rst
  always @(negedge i_mclk) begin
    if (o_done || o_set_limit) begin
      check({o_set_limit, err, stat, ls}, expq.size() ? expq.pop_front() : 'x);
    end
  end
  initial begin
    rst();
    op(8'h02, {1'b1, 16'h0050, MXSEC_UNLOCKED});
    op(8'h05, r(1, MXSEC_UNLOCKED));
    key = 8'($random(seed)) | 8'h01;
    op(8'h01, r(0, MXSEC_UNLOCKED));
    op(8'h02, r(0, MXSEC_LOCKED));
    for (i = 1; i < 3; i++) op(8'(i), r(1, MXSEC_LOCKED));
    op(8'h80, r(1, MXSEC_LOCKED));
    key ^= 8'h80;
    slow = 1;
    op(8'h03, r(1, MXSEC_LOCKED));
    key ^= 8'h80;
    op(8'h03, r(0, MXSEC_UNLOCKED));
    slow = 0;
    op(8'h02, r(0, MXSEC_LOCKED));
    op(8'h04, r(0, MXSEC_FROZEN));
    for (i = 1; i < 6; i++) op(8'(i), r(1, MXSEC_FROZEN));
    op(8'h80, r(1, MXSEC_FROZEN));
    rst();
    key = 8'h00;
    op(8'h03, r(0, MXSEC_UNLOCKED));
    op(8'h02, r(0, MXSEC_LOCKED));
    key = 8'h01;
    for (i = 0; i < 5; i++) op(8'h03, r(1, MXSEC_LOCKED));
    key = 8'h00;
    op(8'h03, r(1, MXSEC_LOCKED));
    op(8'h04, r(0, MXSEC_FROZEN));
    rst();
    op(8'h03, r(0, MXSEC_UNLOCKED));
    stop_test();
  end
endmodule : max_address_security_fsm_tb
bind mxsec_fsm mxsec_monitor mxsec_monitor_inst(.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_data(i_data), .o_data_req(o_data_req), .o_set_limit(o_set_limit), .o_done(o_done),
  .o_command_error_flags(o_command_error_flags),
  .o_device_status_flags(o_device_status_flags), .o_lstate(o_lstate));
